// ---- hw/pwmev_pkg.sv ----
// Constants, register map and carrier types for the timer event/status block.
// Assumes one 100 MHz clock shared by the bus port and the timer logic.
package pwmev_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] PWMEV_OFS_EVENT_INPUT_B_CONFIG = 8'h09;
  localparam logic [7:0] PWMEV_OFS_INTERRUPT_ENABLE = 8'h0C;
  localparam logic [7:0] PWMEV_OFS_INTERRUPT_FLAG = 8'h0D;
  localparam logic [7:0] PWMEV_OFS_TIMER_STATUS = 8'h0E;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int PWMEV_CFG_LSB = 6;
  localparam int PWMEV_POL_BIT = 4;
  localparam int PWMEV_ACT_BIT = 2;
  localparam int PWMEV_TRIG_BIT = 0;
  localparam int PWMEV_IRQ_B_BIT = 3;
  localparam int PWMEV_IRQ_A_BIT = 2;
  localparam int PWMEV_IRQ_OVF_BIT = 0;
  localparam int PWMEV_ACT_B_BIT = 7;
  localparam int PWMEV_ACT_A_BIT = 6;
  localparam int PWMEV_CMD_RDY_BIT = 1;
  localparam int PWMEV_EN_RDY_BIT = 0;
  localparam logic [7:0] PWMEV_CFG_MASK = 8'h00D5;
  localparam logic [7:0] PWMEV_IRQ_MASK = 8'h000D;
  localparam logic [7:0] PWMEV_RST_BYTE = 8'h00;

  // Event configuration codes
  localparam logic [1:0] PWMEV_CFG_NEITHER = 2'h0;
  localparam logic [1:0] PWMEV_CFG_FILTER = 2'h1;
  localparam logic [1:0] PWMEV_CFG_ASYNC = 2'h2;

  // Input mode code meaning no action
  localparam logic [3:0] PWMEV_MODE_NONE = 4'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int PWMEV_CLK_PERIOD_NS = 10;
  localparam int PWMEV_FILTER_SAMPLES = 4;
  localparam int PWMEV_SYNC_TIME_NS = 30;
  localparam int PWMEV_SYNC_CYC =
    (PWMEV_SYNC_TIME_NS + PWMEV_CLK_PERIOD_NS - 1) / PWMEV_CLK_PERIOD_NS;
  localparam logic [3:0] PWMEV_SYNC_LOAD = 4'(PWMEV_SYNC_CYC);

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic sync_at_cycle_end_strobe;
    logic sync_now_strobe;
    logic restart_strobe;
    logic soft_capture_a_strobe;
    logic soft_capture_b_strobe;
  } pwmev_cmd_t;

  typedef struct packed {
    logic fault;
    logic capture;
    logic trigger;
    logic [3:0] mode;
  } pwmev_evt_t;

  typedef enum logic [1:0] {
    PWMEV_EN_IDLE,
    PWMEV_EN_SYNC,
    PWMEV_EN_WAIT_EOC,
    PWMEV_EN_HALT
  } pwmev_en_state_t;

endpackage : pwmev_pkg

// ---- hw/pwmev_top.sv ----
// Second event input conditioning, interrupt enables/flags and status register.
// Assumes all inputs are synchronous to clk_i and strobes are one cycle long.
//
// Notes on behaviour
// [RL1] Filter mode: output follows input only after four equal samples.
// [RL2] Asynchronous mode: event drives the async output straight, bypassing sampling.
// [RL3] Config bits 7:6: 0 none, 1 filter, 2 async, others reserved.
// [RL4] Polarity 0 means falling/low active, 1 means rising/high active.
// [RL5] Action 0 gives fault only, action 1 gives fault plus capture B.
// [RL6] Fault response carries the configured input mode of input B.
// [RL7] Bit 0 of event config routes the event as input B trigger.
// [RL8] Interrupt enable bit 3 gates the input B trigger request.
// [RL9] Interrupt enable bit 2 gates the input A trigger request.
// [RL10] Interrupt enable bit 0 gates the overflow / restart request.
// [RL11] Flag bit 3 set by B trigger or capture, cleared by writing one.
// [RL12] Flag bit 2 set by A trigger or capture, cleared by writing one.
// [RL13] Flag bit 0 set at each cycle end, cleared by writing one.
// [RL14] Status bit 7 set on any output B change, cleared by writing one.
// [RL15] Status bit 6 set on any output A change, cleared by writing one.
// [RL16] Status bit 1 high only when last command is synchronized.
// [RL17] Command ready drops on any of the five command strobes.
// [RL18] With auto update, compare B clear high write drops command ready.
// [RL19] Status bit 0 high only when enable value is synchronized.
// [RL20] Enable ready drops on enable write or disable-at-cycle-end strobe.
// [RL21] Enable ready drops on debug break while run in debug is zero.
// [RL22] Strobes during an ongoing synchronization are ignored.
// [RL23] Each request asserted while flag and enable both set; zero writes keep flags.
// [RL24] One clears activity bits, zero keeps them; ready bits ignore writes.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module pwmev_top
  import pwmev_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic event_b_i,
  input wire logic [3:0] input_mode_b_i,
  input wire logic input_a_trigger_i,
  input wire logic cycle_end_overflow_i,
  input wire logic waveform_out_a_i,
  input wire logic waveform_out_b_i,
  input wire pwmev_cmd_t cmd_strobe_i,
  input wire logic auto_update_i,
  input wire logic compare_b_clear_high_wr_i,
  input wire logic enable_wr_i,
  input wire logic enable_value_i,
  input wire logic disable_at_cycle_end_strobe_i,
  input wire logic debug_break_i,
  input wire logic run_in_debug_i,
  output pwmev_evt_t event_b_o,
  output logic async_event_b_o,
  output pwmev_cmd_t cmd_issue_o,
  output logic timer_enable_o,
  output logic [2:0] irq_o
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] event_input_b_config;
  logic [7:0] interrupt_enable;
  logic [7:0] interrupt_flag;
  logic output_b_activity;
  logic output_a_activity;
  logic command_ready;
  logic enable_ready;

  // ****************************************
  // Bus decode
  // ****************************************
  wire sel_cfg = addr_i == PWMEV_OFS_EVENT_INPUT_B_CONFIG;
  wire sel_ie = addr_i == PWMEV_OFS_INTERRUPT_ENABLE;
  wire sel_flag = addr_i == PWMEV_OFS_INTERRUPT_FLAG;
  wire sel_stat = addr_i == PWMEV_OFS_TIMER_STATUS;
  wire wr_cfg = wr_i & sel_cfg;
  wire wr_ie = wr_i & sel_ie;
  wire wr_flag = wr_i & sel_flag;
  wire wr_stat = wr_i & sel_stat;

  wire [7:0] status_byte = {output_b_activity, output_a_activity, 4'h0,
    command_ready, enable_ready};
  // Unmapped offsets read as zero
  wire [7:0] next_rdata = sel_cfg ? event_input_b_config :
    sel_ie ? interrupt_enable :
    sel_flag ? interrupt_flag :
    sel_stat ? status_byte : PWMEV_RST_BYTE;

  // ****************************************
  // Event configuration fields
  // ****************************************
  // Reserved code 3 matches neither compare and acts as plain sampling
  wire [1:0] cfg_code = event_input_b_config[PWMEV_CFG_LSB +: 2];
  wire filter_on = cfg_code == PWMEV_CFG_FILTER; // [RL3]
  wire async_on = cfg_code == PWMEV_CFG_ASYNC; // [RL3]
  wire polarity = event_input_b_config[PWMEV_POL_BIT];
  wire capture_on = event_input_b_config[PWMEV_ACT_BIT];
  wire event_trigger_enable = event_input_b_config[PWMEV_TRIG_BIT];

  // ****************************************
  // Event input conditioning
  // ****************************************
  logic [PWMEV_FILTER_SAMPLES-1:0] samples;
  logic filtered;
  logic event_q;
  logic active_q;

  wire all_high = &samples;
  wire all_low = ~|samples;
  // Filter only moves once the whole window agrees, at the cost of latency
  wire next_filtered = all_high ? 1'b1 : all_low ? 1'b0 : filtered; // [RL1]
  wire conditioned = filter_on ? filtered : event_q; // [RL1]
  wire active_level = polarity ? conditioned : ~conditioned; // [RL4]
  wire active_edge = active_level & ~active_q; // [RL4]
  // Input mode 0 means no action, so the fault level is held off
  wire fault_allowed = input_mode_b_i != PWMEV_MODE_NONE; // [RL6]
  wire next_fault = active_level & fault_allowed & ~async_on; // [RL2]
  wire next_capture = active_edge & capture_on; // [RL5]
  wire next_trigger = active_edge & event_trigger_enable; // [RL7]
  // Async path skips every flop, so this output alone is combinational
  assign async_event_b_o = async_on & (polarity ? event_b_i : ~event_b_i); // [RL2]

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      samples <= '0;
      filtered <= 1'b0;
      event_q <= 1'b0;
      active_q <= 1'b0;
    end
    else if (ce_i)
    begin
      samples <= {samples[PWMEV_FILTER_SAMPLES-2:0], event_b_i}; // [RL1]
      filtered <= next_filtered; // [RL1]
      event_q <= event_b_i;
      active_q <= active_level;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      event_b_o <= '0;
    else if (ce_i)
    begin
      event_b_o.fault <= next_fault | next_capture; // [RL5]
      event_b_o.capture <= next_capture; // [RL5]
      event_b_o.trigger <= next_trigger; // [RL7]
      event_b_o.mode <= input_mode_b_i; // [RL6]
    end
  end

  // ****************************************
  // Interrupt flags and requests
  // ****************************************
  wire set_b = next_trigger | next_capture;
  wire [7:0] flag_set = {4'h0, set_b, input_a_trigger_i, 1'b0,
    cycle_end_overflow_i};
  wire [7:0] flag_clr = wr_flag ? wdata_i & PWMEV_IRQ_MASK : PWMEV_RST_BYTE;
  // Set wins over a clear in the same cycle
  wire [7:0] next_flag = ((interrupt_flag & ~flag_clr) | flag_set) & PWMEV_IRQ_MASK; // [RL23]
  wire [7:0] next_ie = wr_ie ? wdata_i & PWMEV_IRQ_MASK : interrupt_enable;
  wire [7:0] req = next_flag & next_ie; // [RL23]
  wire [2:0] next_irq = {req[PWMEV_IRQ_B_BIT], req[PWMEV_IRQ_A_BIT],
    req[PWMEV_IRQ_OVF_BIT]}; // [RL8] [RL9] [RL10]

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      interrupt_enable <= PWMEV_RST_BYTE;
      interrupt_flag <= PWMEV_RST_BYTE;
      irq_o <= 3'h0;
    end
    else if (ce_i)
    begin
      interrupt_enable <= next_ie; // [RL8] [RL9] [RL10]
      interrupt_flag <= next_flag; // [RL11] [RL12] [RL13]
      irq_o <= next_irq; // [RL23]
    end
  end

  // Reserved bits are dropped at the write, so they always read back as zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      event_input_b_config <= PWMEV_RST_BYTE;
    else if (ce_i & wr_cfg)
      event_input_b_config <= wdata_i & PWMEV_CFG_MASK; // [RL3]
  end

  // ****************************************
  // Bus read port
  // ****************************************
  // Read data last one cycle and are zero otherwise, so several ports may be ORed
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= PWMEV_RST_BYTE;
    else if (ce_i)
      rdata_o <= rd_i ? next_rdata : PWMEV_RST_BYTE;
  end

  // ****************************************
  // Waveform activity
  // ****************************************
  // A toggle shorter than one clock is not seen, since edges are found by sampling
  logic wave_a_q;
  logic wave_b_q;
  wire clr_act_b = wr_stat & wdata_i[PWMEV_ACT_B_BIT]; // [RL24]
  wire clr_act_a = wr_stat & wdata_i[PWMEV_ACT_A_BIT]; // [RL24]
  wire chg_b = waveform_out_b_i ^ wave_b_q; // [RL14]
  wire chg_a = waveform_out_a_i ^ wave_a_q; // [RL15]

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      output_a_activity <= 1'b0;
      output_b_activity <= 1'b0;
    end
    else if (ce_i)
    begin
      wave_a_q <= waveform_out_a_i;
      wave_b_q <= waveform_out_b_i;
      output_b_activity <= chg_b | (output_b_activity & ~clr_act_b); // [RL14]
      output_a_activity <= chg_a | (output_a_activity & ~clr_act_a); // [RL15]
    end
  end

  // ****************************************
  // Command synchronization
  // ****************************************
  // One counter serves every command, since only one may be in flight
  logic [3:0] cmd_count;
  pwmev_cmd_t cmd_pending;
  wire any_strobe = |cmd_strobe_i; // [RL17]
  wire auto_req = auto_update_i & compare_b_clear_high_wr_i; // [RL18]
  // Strobes landing while busy are dropped, not queued
  wire cmd_accept = command_ready & (any_strobe | auto_req); // [RL22]
  wire cmd_done = ~command_ready & (cmd_count == 4'h1);
  wire [3:0] next_cmd_count = cmd_accept ? PWMEV_SYNC_LOAD :
    (cmd_count != 4'h0) ? cmd_count - 4'h1 : cmd_count;
  // Auto update asks for a load at cycle end
  wire pwmev_cmd_t next_pending = cmd_accept ?
    (cmd_strobe_i | pwmev_cmd_t'({auto_req, 4'h0})) : cmd_pending;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      command_ready <= 1'b0;
      cmd_count <= PWMEV_SYNC_LOAD;
      cmd_pending <= '0;
      cmd_issue_o <= '0;
    end
    else if (ce_i)
    begin
      cmd_count <= next_cmd_count;
      cmd_pending <= next_pending;
      if (cmd_accept)
        command_ready <= 1'b0; // [RL17] [RL18]
      else if (cmd_done)
        command_ready <= 1'b1; // [RL16]
      cmd_issue_o <= cmd_done ? cmd_pending : '0; // [RL16]
    end
  end

  // ****************************************
  // Enable synchronization
  // ****************************************
  pwmev_en_state_t en_state;
  logic [3:0] en_count;
  logic en_value_q;
  // A debug halt parks the enable sync once it is idle; writes during the break are not taken
  wire halted = debug_break_i & ~run_in_debug_i; // [RL21]
  wire en_idle = en_state == PWMEV_EN_IDLE;
  // Only idle takes a request, so a running sync is never cut short
  wire en_write_ok = en_idle & ~halted & enable_wr_i; // [RL20]
  wire dis_ok = en_idle & ~halted & ~enable_wr_i & disable_at_cycle_end_strobe_i; // [RL20]
  wire en_count_end = en_count == 4'h1;
  wire [3:0] next_en_count = en_write_ok ? PWMEV_SYNC_LOAD :
    (en_count != 4'h0) ? en_count - 4'h1 : en_count;
  pwmev_en_state_t next_en_state;

  always_comb
  begin
    next_en_state = en_state;
    case (en_state)
      PWMEV_EN_IDLE:
        if (halted)
          next_en_state = PWMEV_EN_HALT; // [RL21]
        else if (en_write_ok)
          next_en_state = PWMEV_EN_SYNC; // [RL20]
        else if (dis_ok)
          next_en_state = PWMEV_EN_WAIT_EOC; // [RL20]
      PWMEV_EN_SYNC:
        if (en_count_end)
          next_en_state = PWMEV_EN_IDLE; // [RL19]
      PWMEV_EN_WAIT_EOC:
        if (cycle_end_overflow_i)
          next_en_state = PWMEV_EN_IDLE; // [RL19]
      PWMEV_EN_HALT:
        if (~halted)
          next_en_state = PWMEV_EN_IDLE;
      default:
        next_en_state = PWMEV_EN_IDLE;
    endcase
  end

  // Ready is low in every state but idle, and the flop is computed from next state
  wire next_enable_ready = (next_en_state == PWMEV_EN_IDLE) & ~halted; // [RL19] [RL21]
  wire next_enable = (en_state == PWMEV_EN_SYNC & en_count_end) ? en_value_q :
    (en_state == PWMEV_EN_WAIT_EOC & cycle_end_overflow_i) ? 1'b0 : timer_enable_o;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      en_state <= PWMEV_EN_SYNC;
      en_count <= PWMEV_SYNC_LOAD;
      en_value_q <= 1'b0;
      enable_ready <= 1'b0;
      timer_enable_o <= 1'b0;
    end
    else if (ce_i)
    begin
      en_state <= next_en_state;
      en_count <= next_en_count;
      if (en_write_ok)
        en_value_q <= enable_value_i;
      enable_ready <= next_enable_ready; // [RL19] [RL20] [RL21]
      timer_enable_o <= next_enable;
    end
  end

endmodule : pwmev_top

// ---- tb/pwmev_sva.sv ----
// Checker for the event/status block: command, enable, irq and read timing.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ns
module pwmev_sva
  import pwmev_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic cycle_end_overflow_i,
  input wire pwmev_cmd_t cmd_strobe_i,
  input wire logic auto_update_i,
  input wire logic compare_b_clear_high_wr_i,
  input wire logic enable_wr_i,
  input wire pwmev_evt_t event_b_o,
  input wire pwmev_cmd_t cmd_issue_o,
  input wire logic timer_enable_o,
  input wire logic [2:0] irq_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_CMD_DELAY: assert property (
    cmd_issue_o != '0 |-> $past(cmd_strobe_i, 4) != '0 ||
    ($past(auto_update_i, 4) && $past(compare_b_clear_high_wr_i, 4)))
    else $error("command issued without a strobe four cycles earlier");
  AST_CMD_GAP: assert property (
    cmd_issue_o != '0 |=> cmd_issue_o == '0 [*2])
    else $error("commands issued closer than the sync delay");
  AST_EN_SYNC: assert property (
    $rose(timer_enable_o) |-> $past(enable_wr_i, 3) || $past(enable_wr_i, 4))
    else $error("enable rose without a recent enable write");
  AST_IRQ_RISE: assert property (
    $rose(irq_o[0]) |-> $past(cycle_end_overflow_i) || $past(cycle_end_overflow_i, 2)
    || $past(wr_i) || $past(wr_i, 2))
    else $error("overflow request rose without cause");
  AST_IRQ_FALL: assert property (
    ($past(irq_o) & ~irq_o) != 3'h0 |-> $past(wr_i) || $past(wr_i, 2))
    else $error("request fell without a register write");
  AST_RDATA_IDLE: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  AST_TRIG_PULSE: assert property (
    event_b_o.trigger |=> !event_b_o.trigger)
    else $error("trigger longer than one cycle");
  AST_CAP_FAULT: assert property (
    event_b_o.capture |-> event_b_o.fault)
    else $error("capture without fault");
endmodule : pwmev_sva

bind pwmev_top pwmev_sva u_sva (.clk_i, .rst_i, .wr_i, .rd_i, .rdata_o,
  .cycle_end_overflow_i, .cmd_strobe_i, .auto_update_i, .compare_b_clear_high_wr_i,
  .enable_wr_i, .event_b_o, .cmd_issue_o, .timer_enable_o, .irq_o);

// ---- tb/pwmev_far.sv ----
// Model of the event routing side: event level, trigger A and timer cycle.
// Assumes period 0 stops the cycle and freezes the waveforms.
`timescale 1ns/1ns
module pwmev_far
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] period_i,
  input wire logic level_i,
  input wire logic a_req_i,
  output logic event_o,
  output logic trig_a_o,
  output logic ovf_o,
  output logic wo_a_o,
  output logic wo_b_o
);
  logic [7:0] cnt;
  // Routing adds no delay, so the block sees the level as driven
  assign event_o = level_i;
  assign trig_a_o = a_req_i;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      {cnt, ovf_o, wo_a_o, wo_b_o} <= '0;
    else if (period_i == 8'h00)
      {cnt, ovf_o} <= '0;
    else
    begin
      ovf_o <= cnt == period_i - 8'h01;
      cnt <= (cnt == period_i - 8'h01) ? 8'h00 : cnt + 8'h01;
      wo_a_o <= wo_a_o ^ (cnt == 8'h00);
      wo_b_o <= wo_b_o ^ (cnt == period_i / 2);
    end
endmodule : pwmev_far

// ---- tb/testbench.sv ----
// Self-checking bench for the event/status block with the routing model.
// Assumes the bus, strobes and timer inputs share the 100 MHz clock.
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module testbench
  import pwmev_pkg::*;
;
  logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, au = 0, cbw = 0, enw = 0, env = 0;
  logic dis = 0, dbg = 0, rid = 0, lvl = 0, areq = 0, aev, ten, ev, ta, ovf, wa, wb;
  logic [7:0] addr = 0, wdata = 0, rdata, per = 0;
  logic [3:0] mode = 4'h1;
  logic [2:0] irq;
  pwmev_cmd_t cmd = '0, iss, last;
  pwmev_evt_t evt;
  int err_total = 0, compares = 0, npulse = 0, n, lat[2];
  logic [31:0] seed = 32'h1f14_6c26;

  pwmev_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .event_b_i(ev),
    .input_mode_b_i(mode), .input_a_trigger_i(ta), .cycle_end_overflow_i(ovf),
    .waveform_out_a_i(wa), .waveform_out_b_i(wb), .cmd_strobe_i(cmd),
    .auto_update_i(au), .compare_b_clear_high_wr_i(cbw), .enable_wr_i(enw),
    .enable_value_i(env), .disable_at_cycle_end_strobe_i(dis), .debug_break_i(dbg),
    .run_in_debug_i(rid), .event_b_o(evt), .async_event_b_o(aev),
    .cmd_issue_o(iss), .timer_enable_o(ten), .irq_o(irq));
  pwmev_far far (.clk_i(clk_i), .rst_i(rst_i), .period_i(per), .level_i(lvl),
    .a_req_i(areq), .event_o(ev), .trig_a_o(ta), .ovf_o(ovf), .wo_a_o(wa), .wo_b_o(wb));

  // ****
  // Helpers
  // ****
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (iss != '0)
    begin
      npulse++;
      last = iss;
    end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] fl(input logic b, input logic a, input logic o);
    return {4'h0, b, a, 1'b0, o};
  endfunction : fl
  function automatic logic [7:0] cfgv(input logic [1:0] c, input logic p, input logic t);
    return {c, 1'b0, p, 1'b0, p, 1'b0, t};
  endfunction : cfgv
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk_i);
    wr <= 0;
    @(posedge clk_i);
  endtask : wr8
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string s);
    addr <= a;
    rd <= 1;
    @(posedge clk_i);
    rd <= 0;
    @(posedge clk_i);
    `CHK(s, e, rdata)
  endtask : rchk
  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial
  begin
    cyc(20000);
    err_total++;
    summarize();
  end

  // ****
  // Scenarios
  // ****
  initial
  begin
    cyc(5);
    rst_i <= 0;
    cyc(8);
    rchk(PWMEV_OFS_TIMER_STATUS, 8'h03, "status");
    rchk(8'h0A, 8'h00, "unmapped");
    repeat (3)
    begin
      seed = xs(seed);
      wr8(PWMEV_OFS_EVENT_INPUT_B_CONFIG, seed[7:0]);
      rchk(PWMEV_OFS_EVENT_INPUT_B_CONFIG, seed[7:0] & PWMEV_CFG_MASK, "cfg");
      wr8(PWMEV_OFS_INTERRUPT_ENABLE, seed[15:8]);
      rchk(PWMEV_OFS_INTERRUPT_ENABLE, seed[15:8] & PWMEV_IRQ_MASK, "ien");
    end
    wr8(PWMEV_OFS_TIMER_STATUS, 8'hFF);
    rchk(PWMEV_OFS_TIMER_STATUS, 8'h03, "status w");
    for (int c = 0; c < 2; c++)
      for (int p = 0; p < 2; p++)
      begin
        seed = xs(seed);
        mode <= 4'(seed % 10) + 4'h1;
        lvl <= !p[0];
        wr8(PWMEV_OFS_EVENT_INPUT_B_CONFIG, cfgv(2'(c), p[0], 1'b1));
        cyc(8);
        wr8(PWMEV_OFS_INTERRUPT_FLAG, 8'hFF);
        lvl <= p[0];
        for (n = 0; !evt.trigger && n < 20; n++)
          @(posedge clk_i);
        `CHK("capture", p[0], evt.capture)
        lat[c] = n;
        cyc(3);
        `CHK("fault", {1'b1, mode}, {evt.fault, evt.mode})
        rchk(PWMEV_OFS_INTERRUPT_FLAG, fl(1, 0, 0), "flag b");
      end
    `CHK("filter delay", 4, lat[1] - lat[0])
    wr8(PWMEV_OFS_EVENT_INPUT_B_CONFIG, 8'h10);
    lvl <= 0;
    cyc(6);
    wr8(PWMEV_OFS_INTERRUPT_FLAG, 8'hFF);
    mode <= 4'h0;
    lvl <= 1;
    cyc(8);
    `CHK("no fault", 1'b0, evt.fault)
    rchk(PWMEV_OFS_INTERRUPT_FLAG, 8'h00, "no trig");
    wr8(PWMEV_OFS_EVENT_INPUT_B_CONFIG, cfgv(2'h2, 1'b1, 1'b1));
    `CHK("async hi", 1'b1, aev)
    lvl <= 0;
    @(posedge clk_i);
    `CHK("async lo", 1'b0, aev)
    wr8(PWMEV_OFS_EVENT_INPUT_B_CONFIG, cfgv(2'h0, 1'b1, 1'b1));
    wr8(PWMEV_OFS_INTERRUPT_ENABLE, 8'h0D);
    areq <= 1;
    lvl <= 1;
    @(posedge clk_i);
    areq <= 0;
    cyc(6);
    `CHK("irq", 3'b110, irq)
    wr8(PWMEV_OFS_INTERRUPT_FLAG, 8'h00);
    rchk(PWMEV_OFS_INTERRUPT_FLAG, fl(1, 1, 0), "flag keep");
    wr8(PWMEV_OFS_INTERRUPT_ENABLE, 8'h05);
    `CHK("irq mask", 3'b010, irq)
    wr8(PWMEV_OFS_INTERRUPT_FLAG, 8'h0C);
    per <= 8'h0A;
    cyc(30);
    per <= 8'h00;
    cyc(3);
    `CHK("irq ovf", 3'b001, irq)
    rchk(PWMEV_OFS_INTERRUPT_FLAG, fl(0, 0, 1), "ovf");
    rchk(PWMEV_OFS_TIMER_STATUS, 8'hC3, "activity");
    wr8(PWMEV_OFS_TIMER_STATUS, 8'h40);
    rchk(PWMEV_OFS_TIMER_STATUS, 8'h83, "act a clr");
    wr8(PWMEV_OFS_TIMER_STATUS, 8'h80);
    wr8(PWMEV_OFS_INTERRUPT_FLAG, 8'h01);
    rchk(PWMEV_OFS_TIMER_STATUS, 8'h03, "act b clr");
    for (int i = 0; i < 5; i++)
    begin
      cmd <= 5'(1 << i);
      @(posedge clk_i);
      cmd <= 5'(1 << ((i + 1) % 5));
      @(posedge clk_i);
      cmd <= '0;
      rchk(PWMEV_OFS_TIMER_STATUS, 8'h01, "busy");
      cyc(6);
      `CHK("issue", 5'(1 << i), last)
      `CHK("count", i + 1, npulse)
    end
    for (int a = 0; a < 2; a++)
    begin
      au <= a[0];
      cbw <= 1;
      @(posedge clk_i);
      cbw <= 0;
      cyc(6);
      `CHK("auto", 5 + a, npulse)
    end
    `CHK("auto cmd", 5'h10, last)
    enw <= 1;
    env <= 1;
    @(posedge clk_i);
    enw <= 0;
    cyc(6);
    `CHK("enable", 1'b1, ten)
    dis <= 1;
    @(posedge clk_i);
    dis <= 0;
    rchk(PWMEV_OFS_TIMER_STATUS, 8'h02, "dis wait");
    per <= 8'h0A;
    cyc(15);
    per <= 8'h00;
    cyc(3);
    `CHK("disabled", 1'b0, ten)
    wr8(PWMEV_OFS_TIMER_STATUS, 8'hC0);
    dbg <= 1;
    cyc(2);
    rchk(PWMEV_OFS_TIMER_STATUS, 8'h02, "debug");
    dbg <= 0;
    cyc(6);
    rchk(PWMEV_OFS_TIMER_STATUS, 8'h03, "resume");
    rid <= 1;
    dbg <= 1;
    cyc(2);
    rchk(PWMEV_OFS_TIMER_STATUS, 8'h03, "debug run");
    dbg <= 0;
    summarize();
  end
endmodule : testbench
